//--- rtl/ufp_regs.vh
`ifndef UFP_REGS_VH
`define UFP_REGS_VH
// Parameter disable code
`define UFP_DISABLE_CODE   8'hFF
// Frame end check encodings
`define UFP_CHK_NONE       2'h0
`define UFP_CHK_START      2'h1
`define UFP_CHK_STOP       2'h2
`define UFP_CHK_BOTH       2'h3
// Packet, address and inquiry retry limits
`define UFP_PKT_MAX        48
`define UFP_ADDR_MAX       16
`define UFP_INQ_TRIES      5
// Timing in microseconds at a 40 ns clock
`define UFP_CLK_NS         40
`define UFP_GAP_US         400
`define UFP_BOOT_US        100000
`define UFP_RESP_US        50000
`define UFP_GAP_CYC        ((`UFP_GAP_US * 1000) / `UFP_CLK_NS)
`define UFP_BOOT_CYC       ((`UFP_BOOT_US * 1000) / `UFP_CLK_NS)
`define UFP_RESP_CYC       ((`UFP_RESP_US * 1000) / `UFP_CLK_NS)
`endif

//--- rtl/ufp_fifo.v
`timescale 1ns/1ps
// ****************************************
// Small synchronous FIFO
// ****************************************
module ufp_fifo #(
   parameter WIDTH = 9,
   parameter DEPTH = 4,
   parameter AW    = 2
) (
   input  wire             clk_i,
   input  wire             srst_i,
   input  wire             in_valid_i,
   output wire             in_ready_o,
   input  wire [WIDTH-1:0] in_data_i,
   output wire             out_valid_o,
   input  wire             out_ready_i,
   output wire [WIDTH-1:0] out_data_o
);
   reg [WIDTH-1:0] mem_q [0:DEPTH-1];
   reg [AW-1:0]    wr_q;
   reg [AW-1:0]    rd_q;
   reg [AW:0]      cnt_q;
   wire            push;
   wire            pop;

   assign in_ready_o  = (cnt_q != DEPTH[AW:0]);
   assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
   assign out_data_o  = mem_q[rd_q];
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;

   always @(posedge clk_i) begin
      if (push) begin
         mem_q[wr_q] <= in_data_i;
      end
   end

   always @(posedge clk_i) begin
      if (srst_i) begin
         wr_q  <= {AW{1'b0}};
         rd_q  <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
         end
         if (push & ~pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop & ~push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule

//--- rtl/ufp_parser.v
`timescale 1ns/1ps
// Contract
// - Length byte sits at a configured offset from the frame's first byte.
// - Frame length is length byte plus amendment; frame closes after that.
// - End check enables start and stop separately; none means transparent.
// - Enabled start word is first byte, stop word is last byte.
// - Transparent mode forwards bytes as opaque payload.
// - Transparent frame ends when character gap exceeds threshold.
// - Offset or amendment of 255 disables length parsing.
// - Address offset of 255 disables address extraction.
// - No extracted address means downlink is sent as broadcast.
// - Address at offset and length; wildcard bytes match anything.
// - After a complete frame send the ack packet; empty means none.
// - Route by host address or own MAC per configuration.
// - At power-up wait boot time, send inquiry, wait response timeout.
// - Host answers within timeout; device stores extracted address.
// - Retry inquiry up to five attempts then act as relay.
// - After abandoned inquiry, capture address from first host frame.
// - Start and stop sync words are one byte each.
// - Obtained host address is kept until reset.
`include "ufp_regs.vh"
module ufp_parser #(
   parameter GAP_CYC  = `UFP_GAP_CYC,
   parameter BOOT_CYC = `UFP_BOOT_CYC,
   parameter RESP_CYC = `UFP_RESP_CYC,
   parameter AL       = `UFP_ADDR_MAX,
   parameter PM       = `UFP_PKT_MAX
) (
   input  wire            clk_i,
   input  wire            srst_i,
   input  wire            rx_valid_i,
   input  wire [7:0]      rx_data_i,
   input  wire [1:0]      end_check_i,
   input  wire [7:0]      start_word_i,
   input  wire [7:0]      stop_word_i,
   input  wire [7:0]      len_offset_i,
   input  wire [7:0]      len_amend_i,
   input  wire [7:0]      dl_addr_offset_i,
   input  wire [4:0]      addr_len_i,
   input  wire [7:0]      bcast_wild_i,
   input  wire [7:0]      mcast_wild_i,
   input  wire [8*AL-1:0] match_addr_i,
   input  wire [5:0]      ack_len_i,
   input  wire [8*PM-1:0] ack_pkt_i,
   input  wire [5:0]      inq_len_i,
   input  wire [8*PM-1:0] inq_pkt_i,
   output reg             pay_valid_o,
   input  wire            pay_ready_i,
   output reg  [7:0]      pay_data_o,
   output reg             pay_last_o,
   output reg             frame_ok_o,
   output reg             frame_drop_o,
   output reg             bcast_o,
   output reg             addr_match_o,
   output reg             tx_valid_o,
   output reg  [7:0]      tx_data_o,
   input  wire            tx_ready_i,
   output reg  [8*AL-1:0] host_addr_o,
   output reg             host_addr_ok_o,
   output reg             use_host_addr_o,
   output reg             relay_only_o
);
   // ****************************************
   // Receive parsing
   // ****************************************
   localparam IS_BOOT = 3'h0;
   localparam IS_SEND = 3'h1;
   localparam IS_WAIT = 3'h2;
   localparam IS_DONE = 3'h3;
   localparam IS_GIVE = 3'h4;

   wire       transp = (end_check_i == `UFP_CHK_NONE);
   wire       chk_st = end_check_i[0];
   wire       chk_sp = end_check_i[1];
   wire       len_en = (len_offset_i != `UFP_DISABLE_CODE) &&
                       (len_amend_i != `UFP_DISABLE_CODE);
   wire       adr_en = (dl_addr_offset_i != `UFP_DISABLE_CODE) && !transp;

   reg  [7:0] idx_q;
   reg        in_frm_q;
   reg        bad_q;
   reg  [8:0] tot_q;
   reg        tot_ok_q;
   reg  [7:0] last_q;
   reg [31:0] gap_q;
   reg [AL-1:0] mm_q;
   reg [8*AL-1:0] cap_q;
   reg        fifo_in_v;
   wire       fifo_in_r;
   reg  [8:0] fifo_in_d;
   wire       fifo_out_v;
   wire [8:0] fifo_out_d;
   reg        close_d;
   reg        ok_d;
   wire       take = rx_valid_i && fifo_in_r;
   wire       gap_end = in_frm_q && transp && (gap_q >= GAP_CYC);
   wire [8:0] len_tot = {1'b0, rx_data_i} + {1'b0, len_amend_i};
   wire       st_bad = chk_st && (rx_data_i != start_word_i);

   always @* begin
      close_d = 1'b0;
      ok_d    = 1'b0;
      if (gap_end) begin
         close_d = 1'b1;
         ok_d    = 1'b1;
      end else if (take && in_frm_q && !transp) begin
         if (len_en && tot_ok_q && ({1'b0, idx_q} + 9'h001 == tot_q)) begin
            close_d = 1'b1;
            ok_d    = !bad_q && !(chk_sp && rx_data_i != stop_word_i);
         end else if (!len_en && chk_sp && rx_data_i == stop_word_i) begin
            close_d = 1'b1;
            ok_d    = !bad_q;
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < AL; g = g + 1) begin : g_adr
         localparam [7:0] GOFF = g;
         wire [7:0] pos = dl_addr_offset_i + GOFF;
         wire [7:0] mb  = match_addr_i[8*g +: 8];
         always @(posedge clk_i) begin
            if (srst_i) begin
               mm_q[g]         <= 1'b0;
               cap_q[8*g +: 8] <= 8'h00;
            end else if (take && (!in_frm_q ? 8'h00 : idx_q) == pos) begin
               cap_q[8*g +: 8] <= rx_data_i;
               mm_q[g] <= (g >= addr_len_i) || (rx_data_i == mb) ||
                          (rx_data_i == bcast_wild_i) || (rx_data_i == mcast_wild_i);
            end else if (take && !in_frm_q) begin
               mm_q[g] <= (g >= addr_len_i);
            end
         end
      end
   endgenerate

   always @(posedge clk_i) begin
      if (srst_i) begin
         idx_q <= 8'h00; in_frm_q <= 1'b0; bad_q <= 1'b0;
         tot_q <= 9'h000; tot_ok_q <= 1'b0; last_q <= 8'h00; gap_q <= 32'h0;
         frame_ok_o <= 1'b0; frame_drop_o <= 1'b0;
         bcast_o <= 1'b0; addr_match_o <= 1'b0;
      end else begin
         frame_ok_o   <= close_d && ok_d;
         frame_drop_o <= close_d && !ok_d;
         if (close_d) begin
            bcast_o      <= !adr_en;
            addr_match_o <= adr_en && (&mm_q);
         end
         gap_q <= take ? 32'h0 : gap_q + 32'h1;
         if (close_d) begin
            in_frm_q <= 1'b0;
            idx_q    <= 8'h00;
            tot_ok_q <= 1'b0;
         end else if (take) begin
            if (!in_frm_q) begin
               if (!st_bad) begin
                  in_frm_q <= 1'b1;
                  idx_q    <= 8'h01;
                  bad_q    <= 1'b0;
               end
            end else begin
               idx_q <= idx_q + 8'h01;
               if (len_en && idx_q == len_offset_i) begin
                  tot_q    <= len_tot;
                  tot_ok_q <= 1'b1;
               end
            end
            last_q <= rx_data_i;
         end
      end
   end

   always @* begin
      fifo_in_v = take && (in_frm_q || !st_bad);
      fifo_in_d = {close_d && take, rx_data_i};
   end

   // ****************************************
   // Output buffer
   // ****************************************
   ufp_fifo #(.WIDTH(9), .DEPTH(4), .AW(2)) u_fifo (
      .clk_i       (clk_i),
      .srst_i      (srst_i),
      .in_valid_i  (fifo_in_v),
      .in_ready_o  (fifo_in_r),
      .in_data_i   (fifo_in_d),
      .out_valid_o (fifo_out_v),
      .out_ready_i (!pay_valid_o || pay_ready_i),
      .out_data_o  (fifo_out_d)
   );

   always @(posedge clk_i) begin
      if (srst_i) begin
         pay_valid_o <= 1'b0; pay_data_o <= 8'h00; pay_last_o <= 1'b0;
      end else if (!pay_valid_o || pay_ready_i) begin
         pay_valid_o <= fifo_out_v;
         pay_data_o  <= fifo_out_d[7:0];
         pay_last_o  <= fifo_out_d[8];
      end
   end

   // ****************************************
   // Inquiry and acknowledge transmit
   // ****************************************
   reg  [2:0]  ist_q;
   reg  [31:0] tmr_q;
   reg  [2:0]  try_q;
   reg  [5:0]  tx_idx_q;
   reg         tx_ack_q;
   reg         tx_busy_q;
   reg         ack_pend_q;
   wire [5:0]  tx_len = tx_ack_q ? ack_len_i : inq_len_i;
   wire [8*PM-1:0] tx_pkt = tx_ack_q ? ack_pkt_i : inq_pkt_i;
   wire        got_frm = frame_ok_o && !host_addr_ok_o && adr_en;

   always @(posedge clk_i) begin
      if (srst_i) begin
         ist_q <= IS_BOOT; tmr_q <= 32'h0; try_q <= 3'h0;
         tx_idx_q <= 6'h00; tx_ack_q <= 1'b0; tx_busy_q <= 1'b0;
         ack_pend_q <= 1'b0; tx_valid_o <= 1'b0; tx_data_o <= 8'h00;
         host_addr_o <= {8*AL{1'b0}}; host_addr_ok_o <= 1'b0;
         use_host_addr_o <= 1'b0; relay_only_o <= 1'b0;
      end else begin
         use_host_addr_o <= (inq_len_i != 6'h00);
         if (frame_ok_o && ack_len_i != 6'h00) begin
            ack_pend_q <= 1'b1;
         end
         if (got_frm && ist_q != IS_BOOT && ist_q != IS_SEND) begin
            host_addr_o    <= cap_q;
            host_addr_ok_o <= 1'b1;
         end
         if (tx_valid_o && !tx_ready_i) begin
            tx_valid_o <= 1'b1;
         end else if (tx_busy_q) begin
            if (tx_idx_q < tx_len && tx_idx_q < PM[5:0]) begin
               tx_valid_o <= 1'b1;
               tx_data_o  <= tx_pkt[8*tx_idx_q +: 8];
               tx_idx_q   <= tx_idx_q + 6'h01;
            end else begin
               tx_valid_o <= 1'b0;
               tx_busy_q  <= 1'b0;
            end
         end else if (ack_pend_q && !(frame_ok_o && ack_len_i != 6'h00)) begin
            ack_pend_q <= 1'b0;
            tx_ack_q   <= 1'b1;
            tx_busy_q  <= 1'b1;
            tx_idx_q   <= 6'h00;
            tx_valid_o <= 1'b0;
         end else begin
            tx_valid_o <= 1'b0;
         end
         case (ist_q)
            IS_BOOT: begin
               if (inq_len_i == 6'h00) begin
                  ist_q <= IS_DONE;
               end else if (tmr_q + 32'h1 >= BOOT_CYC) begin
                  ist_q <= IS_SEND;
                  tmr_q <= 32'h0;
               end else begin
                  tmr_q <= tmr_q + 32'h1;
               end
            end
            IS_SEND: begin
               if (!tx_busy_q && !ack_pend_q && !tx_valid_o) begin
                  tx_ack_q  <= 1'b0;
                  tx_busy_q <= 1'b1;
                  tx_idx_q  <= 6'h00;
                  try_q     <= try_q + 3'h1;
                  tmr_q     <= 32'h0;
                  ist_q     <= IS_WAIT;
               end
            end
            IS_WAIT: begin
               if (got_frm) begin
                  ist_q <= IS_DONE;
               end else if (tmr_q + 32'h1 >= RESP_CYC) begin
                  if (try_q >= `UFP_INQ_TRIES) begin
                     ist_q        <= IS_GIVE;
                     relay_only_o <= 1'b1;
                  end else begin
                     ist_q <= IS_SEND;
                  end
               end else if (!tx_busy_q) begin
                  tmr_q <= tmr_q + 32'h1;
               end
            end
            IS_GIVE: begin
               if (got_frm) begin
                  relay_only_o <= 1'b0;
                  ist_q        <= IS_DONE;
               end
            end
            IS_DONE: begin
               ist_q <= IS_DONE;
            end
            default: begin
               ist_q <= IS_BOOT;
            end
         endcase
      end
   end
endmodule

//--- tb/ufp_parser_asserts.sv
`timescale 1ns/1ps
module ufp_parser_asserts #(
   parameter BOOT_CYC = 50,
   parameter AL       = 16
) (
   input wire            clk_i,
   input wire            srst_i,
   input wire [7:0]      dl_addr_offset_i,
   input wire [5:0]      inq_len_i,
   input wire            pay_valid_o,
   input wire            pay_ready_i,
   input wire [7:0]      pay_data_o,
   input wire            frame_ok_o,
   input wire            frame_drop_o,
   input wire            bcast_o,
   input wire            tx_valid_o,
   input wire [7:0]      tx_data_o,
   input wire            tx_ready_i,
   input wire [8*AL-1:0] host_addr_o,
   input wire            host_addr_ok_o,
   input wire            use_host_addr_o,
   input wire            relay_only_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (srst_i);
   // ****
   // Cycles since reset and bytes sent
   // ****
   reg [15:0] age_q;
   reg [15:0] txn_q;
   always @(posedge clk_i) begin
      if (srst_i) begin
         age_q <= 16'h0000;
         txn_q <= 16'h0000;
      end else begin
         if (age_q != 16'hFFFF)
            age_q <= age_q + 16'h0001;
         if (tx_valid_o && tx_ready_i)
            txn_q <= txn_q + 16'h0001;
      end
   end
   close_excl_a : assert property (
      !(frame_ok_o && frame_drop_o)) else $error("frame closed good and bad");
   pay_hold_a : assert property (
      pay_valid_o && !pay_ready_i |=> pay_valid_o && $stable(pay_data_o))
      else $error("payload byte not held");
   tx_hold_a : assert property (
      tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
      else $error("transmit byte not held");
   no_addr_bcast_a : assert property (
      frame_ok_o && dl_addr_offset_i == 8'hFF |-> ##[0:1] bcast_o)
      else $error("frame without address not broadcast");
   host_addr_keep_a : assert property (
      host_addr_ok_o |=> host_addr_ok_o && $stable(host_addr_o))
      else $error("host address changed");
   addr_mode_a : assert property (
      !$past(srst_i) && !$past(srst_i, 2) |-> use_host_addr_o == (inq_len_i != 6'h00))
      else $error("address mode wrong");
   boot_wait_a : assert property (
      tx_valid_o |-> age_q >= BOOT_CYC - 1) else $error("sent before boot time");
   relay_tries_a : assert property (
      $rose(relay_only_o) |-> txn_q == 5 * inq_len_i)
      else $error("relay after wrong number of inquiries");
endmodule
bind ufp_parser ufp_parser_asserts #(.BOOT_CYC(BOOT_CYC), .AL(AL)) i_chk (
   .clk_i, .srst_i, .dl_addr_offset_i, .inq_len_i, .pay_valid_o, .pay_ready_i,
   .pay_data_o, .frame_ok_o, .frame_drop_o, .bcast_o, .tx_valid_o, .tx_data_o,
   .tx_ready_i, .host_addr_o, .host_addr_ok_o, .use_host_addr_o, .relay_only_o);

//--- tb/ufp_host_model.sv
`timescale 1ns/1ps
module ufp_host_model (
   input  wire       clk_i,
   input  wire       tx_valid_i,
   input  wire [7:0] tx_data_i,
   output reg        tx_ready_o,
   output reg        rx_valid_o,
   output reg  [7:0] rx_data_o
);
   logic [7:0] got [$];
   initial begin
      tx_ready_o = 1'b1;
      rx_valid_o = 1'b0;
      rx_data_o = 8'h00;
   end
   // Host takes bytes with random stalls
   always @(negedge clk_i) tx_ready_o <= ($urandom % 4) != 0;
   always @(posedge clk_i)
      if (tx_valid_i && tx_ready_o)
         got.push_back(tx_data_i);
   task automatic send(input logic [7:0] b, input int gap);
      @(negedge clk_i);
      rx_valid_o = 1'b1;
      rx_data_o = b;
      @(negedge clk_i);
      rx_valid_o = 1'b0;
      // No stale byte on an idle line
      rx_data_o = ~b;
      repeat (gap) @(negedge clk_i);
   endtask
endmodule

//--- tb/uart_frame_parser_addr_inquiry_tb.sv
`timescale 1ns/1ps
module uart_frame_parser_addr_inquiry_tb;
   localparam GAP = 20;
   localparam BOOT = 50;
   localparam RESP = 100;
   logic         clk_i = 1'b0;
   logic         srst_i = 1'b1;
   logic         pay_ready_i;
   logic [1:0]   end_check_i;
   logic [7:0]   start_word_i, stop_word_i, len_offset_i, len_amend_i;
   logic [7:0]   dl_addr_offset_i, bcast_wild_i, mcast_wild_i;
   logic [4:0]   addr_len_i;
   logic [127:0] match_addr_i;
   logic [5:0]   ack_len_i, inq_len_i;
   logic [383:0] ack_pkt_i, inq_pkt_i;
   wire          rx_valid_i, tx_ready_i, pay_valid_o, pay_last_o, frame_ok_o;
   wire          frame_drop_o, bcast_o, addr_match_o, tx_valid_o;
   wire          host_addr_ok_o, use_host_addr_o, relay_only_o;
   wire  [7:0]   rx_data_i, pay_data_o, tx_data_o;
   wire  [127:0] host_addr_o;
   int           mismatches = 0;
   int           comparisons = 0;
   int           n_ok, k;
   int           n_drop, n_last;
   logic [7:0]   pay_q [$];
   logic [7:0]   fr [$];
   logic [7:0]   wl [3];
   logic [1:0]   md [2] = '{2'h1, 2'h2};
   always #20 clk_i = ~clk_i;
   ufp_parser #(.GAP_CYC(GAP), .BOOT_CYC(BOOT), .RESP_CYC(RESP)) i_dut (
      .clk_i, .srst_i, .rx_valid_i, .rx_data_i, .end_check_i, .start_word_i,
      .stop_word_i, .len_offset_i, .len_amend_i, .dl_addr_offset_i, .addr_len_i,
      .bcast_wild_i, .mcast_wild_i, .match_addr_i, .ack_len_i, .ack_pkt_i,
      .inq_len_i, .inq_pkt_i, .pay_valid_o, .pay_ready_i, .pay_data_o, .pay_last_o,
      .frame_ok_o, .frame_drop_o, .bcast_o, .addr_match_o, .tx_valid_o, .tx_data_o,
      .tx_ready_i, .host_addr_o, .host_addr_ok_o, .use_host_addr_o, .relay_only_o);
   ufp_host_model i_host (.clk_i, .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o),
      .tx_ready_o(tx_ready_i), .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i));
   always @(posedge clk_i) begin
      if (frame_ok_o)
         n_ok++;
      if (frame_drop_o)
         n_drop++;
      if (pay_valid_o && pay_ready_i && pay_last_o)
         n_last++;
      if (pay_valid_o && pay_ready_i)
         pay_q.push_back(pay_data_o);
   end
   always @(negedge clk_i) pay_ready_i <= ($urandom % 4) != 0;
   // ****
   // Helpers
   // ****
   function automatic int relay_bytes(input int il);
      return 5 * il;
   endfunction
   function automatic logic [15:0] le16(input logic [7:0] b0, b1);
      return {b1, b0};
   endfunction
   task automatic chk(input string nm, input logic [127:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   task automatic restart(input logic [1:0] ec, input logic [7:0] lo, la, ao,
                          input logic [5:0] il);
      srst_i = 1'b1;
      end_check_i = ec;
      len_offset_i = lo;
      len_amend_i = la;
      dl_addr_offset_i = ao;
      inq_len_i = il;
      repeat (6) @(negedge clk_i);
      srst_i = 1'b0;
      n_ok = 0;
      n_drop = 0;
      n_last = 0;
      pay_q.delete();
      i_host.got.delete();
   endtask
   task automatic send_fr(input int gap);
      foreach (fr[i]) i_host.send(fr[i], gap);
      repeat (GAP + 10) @(negedge clk_i);
   endtask
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk_i);
      mismatches++;
      $display("watchdog expired");
      stop_test;
   end
   initial begin
      k = $urandom(32'hDD4B);
      pay_ready_i = 1'b1;
      start_word_i = 8'h68;
      stop_word_i = 8'h16;
      addr_len_i = 5'h02;
      bcast_wild_i = 8'h99;
      mcast_wild_i = 8'hAA;
      match_addr_i = 128'hA1A0;
      ack_len_i = 6'h03;
      ack_pkt_i = '0;
      ack_pkt_i[23:0] = 24'($urandom);
      inq_pkt_i = '0;
      inq_pkt_i[15:0] = 16'($urandom);
      restart(2'h3, 8'hFF, 8'hFF, 8'h01, 6'h02);
      for (k = 0; k < BOOT + RESP && i_host.got.size() < 2; k++) @(negedge clk_i);
      chk("inquiry", {i_host.got[1], i_host.got[0]}, inq_pkt_i[15:0]);
      fr = '{8'h68, 8'hA0, 8'hA1, 8'h16};
      send_fr(2);
      chk("host_ok", host_addr_ok_o, 1'b1);
      chk("host_addr", host_addr_o[15:0], le16(8'hA0, 8'hA1));
      chk("use_host", use_host_addr_o, 1'b1);
      chk("match", addr_match_o, 1'b1);
      chk("ack", {i_host.got[4], i_host.got[3], i_host.got[2]}, ack_pkt_i[23:0]);
      wl = '{bcast_wild_i, mcast_wild_i, 8'h55};
      foreach (wl[i]) begin
         fr = '{8'h68, wl[i], 8'hA1, 8'h16};
         send_fr(2);
         chk("wild", addr_match_o, wl[i] != 8'h55);
      end
      chk("kept", host_addr_o[15:0], le16(8'hA0, 8'hA1));
      n_ok = 0;
      fr = '{8'h55, 8'hA0, 8'hA1, 8'h16, 8'h68, 8'hA0, 8'hA1, 8'h16};
      send_fr(2);
      chk("resync", n_ok, 1);
      $display("test inquiry done");
      restart(2'h3, 8'hFF, 8'hFF, 8'h01, 6'h02);
      for (k = 0; k < 2000 && relay_only_o !== 1'b1; k++) @(negedge clk_i);
      chk("relay", relay_only_o, 1'b1);
      chk("tries", i_host.got.size(), relay_bytes(2));
      chk("no_addr", host_addr_ok_o, 1'b0);
      fr = '{8'h68, 8'hB0, 8'hB1, 8'h16};
      send_fr(2);
      chk("late_addr", host_addr_o[15:0], le16(8'hB0, 8'hB1));
      $display("test relay done");
      restart(2'h0, 8'hFF, 8'hFF, 8'hFF, 6'h00);
      fr.delete();
      repeat (3 + $urandom % 4) fr.push_back(8'($urandom));
      send_fr(GAP - 6);
      chk("use_mac", use_host_addr_o, 1'b0);
      chk("frames", n_ok, 1);
      chk("bcast", bcast_o, 1'b1);
      chk("pay_n", pay_q.size(), fr.size());
      foreach (fr[i]) chk("pay", pay_q[i], fr[i]);
      chk("ack_n", i_host.got.size(), 3);
      $display("test transparent done");
      ack_len_i = 6'h00;
      foreach (md[i]) begin
         restart(md[i], 8'h02, 8'h04, 8'hFF, 6'h00);
         k = 1 + $urandom % 4;
         fr = '{8'h68, 8'($urandom), 8'(k)};
         repeat (k) fr.push_back(8'($urandom));
         send_fr(1);
         chk("early", n_ok, 0);
         fr = '{8'h16};
         send_fr(1);
         chk("closed", n_ok, 1);
         chk("last", n_last, 1);
         fr = '{8'h68, 8'h00, 8'h00, 8'h17};
         send_fr(1);
         chk("drop", n_drop, md[i][1]);
         chk("good", n_ok, 2 - md[i][1]);
         chk("no_ack", i_host.got.size(), 0);
      end
      $display("test length done");
      stop_test;
   end
endmodule
